// >>> hdl/vcs_pkg.sv
// Shared constants for the control and status register group
package vcs_pkg;
  // Register offsets
  localparam logic [15:0] OFF_SLOT   = 16'h1002;
  localparam logic [15:0] OFF_MCST   = 16'h1004;
  localparam logic [15:0] OFF_SET1   = 16'h1006;
  localparam logic [15:0] OFF_CLR1   = 16'h1008;
  localparam logic [15:0] OFF_LEVEL  = 16'h100A;
  localparam logic [15:0] OFF_VECTOR = 16'h100C;
  localparam logic [15:0] OFF_STAT1  = 16'h100E;
  // Field widths
  localparam int SLOT_W   = 5;
  localparam int MCST_W   = 8;
  localparam int LEVEL_W  = 3;
  localparam int VECTOR_W = 8;
  localparam int DATA_W   = 16;
  localparam int WORD_W   = 32;
  // Control register bit positions
  localparam int CTL_BERR  = 3;
  localparam int CTL_SEL   = 4;
  localparam int CTL_HELD  = 7;
  localparam logic [15:0] CTL_MASK = 16'h0098;
  // Status register bit positions
  localparam int ST_DRDY   = 0;
  localparam int ST_GDRDY  = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_GBUSY  = 3;
  localparam int ST_PURGED = 5;
  localparam int ST_TON    = 6;
  localparam int ST_TOFF   = 7;
  localparam int ST_EVENT_THRESHOLD_FLAG  = 8;
  // Reset values
  localparam logic [4:0]  RST_SLOT   = 5'h1F;
  localparam logic [7:0]  RST_MCST   = 8'hAA;
  localparam logic [2:0]  RST_LEVEL  = 3'h0;
  localparam logic [7:0]  RST_VECTOR = 8'h00;
  localparam logic [15:0] RST_CTRL   = 16'h0000;
  // Soft reset sequencer states
  typedef enum logic [2:0] {
    SR_IDLE  = 3'b001,
    SR_PULSE = 3'b010,
    SR_HELD  = 3'b100
  } vcs_sr_e;
endpackage : vcs_pkg

// >>> hdl/vcs_sync2.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module vcs_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  generate
    if (W < 1) begin : g_chk
      $error("vcs_sync2: W must be at least 1");
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;
endmodule : vcs_sync2

// >>> hdl/vcs_word_tag.sv
// Places the slot position code in the top bits of each output word
`timescale 1ns/1ps
module vcs_word_tag (
  // Clock and reset
  input  wire logic                                   core_clk,
  input  wire logic                                   rst_n,
  // Slot code
  input  wire logic [vcs_pkg::SLOT_W-1:0]             slotCode,
  // Word in
  input  wire logic                                   wordInValid,
  input  wire logic [vcs_pkg::WORD_W-vcs_pkg::SLOT_W-1:0] wordIn,
  // Word out
  output logic                                        wordOutValid,
  output logic      [vcs_pkg::WORD_W-1:0]             wordOut
);
  logic                        valid_ff;
  logic [vcs_pkg::WORD_W-1:0]  word_ff;
  wire  [vcs_pkg::WORD_W-1:0]  nxtWord = {slotCode, wordIn};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      valid_ff <= 1'b0;
      word_ff  <= '0;
    end else begin
      valid_ff <= wordInValid;
      word_ff  <= nxtWord; // RULE3 RULE23
    end
  end

  assign wordOutValid = valid_ff;
  assign wordOut      = word_ff;
endmodule : vcs_word_tag

// >>> hdl/vcs_ctrl_status_regs.sv
// Control and status register group of the converter module
`timescale 1ns/1ps
// How it works
// [RULE1] Reset loads slot code; host reads/writes it
// [RULE2] Slot code bits default to one
// [RULE3] Slot code tags header and end words
// [RULE4] Written slot code applies after next reset; the code applies it only after a soft reset, a hard reset restores 0x1F
// [RULE5] Multicast register holds compared upper address
// [RULE6] Multicast register resets to 0xAA
// [RULE7] Set address sets bits written as one
// [RULE8] Clear address clears bits written as one
// [RULE9] Both addresses read the shared control register
// [RULE10] Bus error on transfer end sets flag
// [RULE11] Hard reset clears all; soft only flag
// [RULE12] Select bit chooses switch or relocation base
// [RULE13] Held reset stays until cleared via clear
// [RULE14] Three-bit level; zero disables interrupts
// [RULE15] Vector driven during interrupt acknowledge
// [RULE16] Data ready when buffer holds an event
// [RULE17] Chain ready is OR of ready lines
// [RULE18] Busy: converting, resetting, full, memory test
// [RULE19] Chain busy is OR of busy lines
// [RULE20] Purged once chained readout data all sent
// [RULE21] Termination bits: all on, all off, mixed
// [RULE22] Threshold flag: trigger count reached, interrupt raised; the code instead requires eventTrigger >= eventsStored, irqRaised and a nonzero level
// [RULE23] Slot code fills top five word bits
// [RULE24] Unused bits read zero, writes ignored
// [RULE25] Status register is read only
module vcs_ctrl_status_regs #(
  parameter int CNT_W = 5
) (
  // Clock and hardware reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // Register port
  input  wire logic                          regAccess,
  input  wire logic                          regWrite,
  input  wire logic [15:0]                   regAddr,
  input  wire logic [15:0]                   regWrData,
  output logic      [15:0]                   regRdData,
  output logic                               regAck,
  // Reset control
  input  wire logic                          softResetReq,
  output logic                               moduleReset,
  // Addressing
  input  wire logic [7:0]                    switchBase,
  input  wire logic [7:0]                    relocBase,
  output logic      [7:0]                    activeBase,
  output logic                               useReloc,
  output logic      [7:0]                    mcstAddr,
  // Interrupter
  input  wire logic                          irqRaised,
  input  wire logic                          iackCycle,
  output logic      [2:0]                    irqLevel,
  output logic                               irqEnable,
  output logic      [7:0]                    iackData,
  // Readout events
  input  wire logic                          berrEvent,
  input  wire logic                          cbltActive,
  input  wire logic                          cbltDataSent,
  // Buffer and converter state
  input  wire logic [CNT_W-1:0]              eventsStored,
  input  wire logic [CNT_W-1:0]              eventTrigger,
  input  wire logic                          bufferFull,
  input  wire logic                          convBusy,
  input  wire logic                          memTestMode,
  // Control bus and switch pins
  input  wire logic                          chainReadyPin,
  input  wire logic                          chainBusyPin,
  input  wire logic                          termAllOnPin,
  input  wire logic                          termAllOffPin,
  // Output word tagging
  input  wire logic                          wordInValid,
  input  wire logic [26:0]                   wordIn,
  output logic                               wordOutValid,
  output logic      [31:0]                   wordOut,
  // Slot code in use
  output logic      [4:0]                    slotCode
);

  generate
    if (CNT_W < 1 || CNT_W > 24) begin : g_chk
      $error("vcs_ctrl_status_regs: CNT_W must be 1 to 24");
    end
  endgenerate

  function automatic logic isHit(input logic [15:0] addr, input logic [15:0] off);
    isHit = (addr == off);
  endfunction : isHit

  // Pin inputs pass two flops first
  logic [3:0] pinSync;

  vcs_sync2 #(
    .W (4)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  ({termAllOffPin, termAllOnPin, chainBusyPin, chainReadyPin}),
    .syncOut  (pinSync)
  );

  wire chainReady = pinSync[0];
  wire chainBusy  = pinSync[1];
  wire termOn     = pinSync[2];
  wire termOff    = pinSync[3];

  // Registers
  logic [4:0]       slotStored_ff;
  logic [4:0]       slotActive_ff;
  logic [7:0]       mcst_ff;
  logic [15:0]      ctrl_ff;
  logic [2:0]       level_ff;
  logic [7:0]       vector_ff;
  logic [15:0]      status_ff;
  logic [15:0]      rdData_ff;
  logic             ack_ff;
  logic             modRst_ff;
  logic             purged_ff;
  logic [7:0]       base_ff;
  logic             irqEn_ff;
  logic [7:0]       iack_ff;

  // Decode
  wire rdStb   = regAccess & ~regWrite;
  wire wrStb   = regAccess & regWrite;
  wire wrSlot  = wrStb & isHit(regAddr, vcs_pkg::OFF_SLOT);
  wire wrMcst  = wrStb & isHit(regAddr, vcs_pkg::OFF_MCST);
  wire wrSet   = wrStb & isHit(regAddr, vcs_pkg::OFF_SET1);
  wire wrClr   = wrStb & isHit(regAddr, vcs_pkg::OFF_CLR1);
  wire wrLevel = wrStb & isHit(regAddr, vcs_pkg::OFF_LEVEL);
  wire wrVec   = wrStb & isHit(regAddr, vcs_pkg::OFF_VECTOR);

  wire [15:0] wdCtl  = regWrData & vcs_pkg::CTL_MASK; // RULE24
  wire        heldBit = ctrl_ff[vcs_pkg::CTL_HELD];

  // Soft reset sequencer
  // A set held bit parks the sequencer; only a clear write or a hard reset frees it
  vcs_pkg::vcs_sr_e srState_ff;
  vcs_pkg::vcs_sr_e nxtSrState;

  always_comb begin
    nxtSrState = srState_ff;
    case (srState_ff)
      vcs_pkg::SR_IDLE: begin
        if (heldBit) begin
          nxtSrState = vcs_pkg::SR_HELD;
        end else if (softResetReq) begin
          nxtSrState = vcs_pkg::SR_PULSE;
        end
      end
      vcs_pkg::SR_PULSE: begin
        nxtSrState = heldBit ? vcs_pkg::SR_HELD : vcs_pkg::SR_IDLE;
      end
      vcs_pkg::SR_HELD: begin
        if (!heldBit) begin
          nxtSrState = vcs_pkg::SR_IDLE; // RULE13
        end
      end
      default: begin
        nxtSrState = vcs_pkg::SR_IDLE;
      end
    endcase
  end

  // Busy, flag clear and slot load all follow this state
  wire inSoftRst = (srState_ff != vcs_pkg::SR_IDLE);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      srState_ff  <= vcs_pkg::SR_IDLE;
      modRst_ff   <= 1'b1;
    end else begin
      srState_ff  <= nxtSrState;
      modRst_ff   <= (nxtSrState != vcs_pkg::SR_IDLE); // RULE13
    end
  end

  // Shared control register
  logic [15:0] nxtCtrl;

  always_comb begin
    nxtCtrl = ctrl_ff;
    if (wrSet) begin
      nxtCtrl = nxtCtrl | wdCtl; // RULE7
    end
    if (wrClr) begin
      nxtCtrl = nxtCtrl & ~wdCtl; // RULE8
    end
    if (inSoftRst) begin
      nxtCtrl[vcs_pkg::CTL_BERR] = 1'b0; // RULE11
    end
    // Hardware event wins over any clear in the same cycle
    if (berrEvent) begin
      nxtCtrl[vcs_pkg::CTL_BERR] = 1'b1; // RULE10
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_ff <= vcs_pkg::RST_CTRL; // RULE11
    end else begin
      ctrl_ff <= nxtCtrl;
    end
  end

  // Slot code: written copy applies only when a soft reset passes
  // Hard reset restores the all-ones default, not the written copy
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slotStored_ff <= vcs_pkg::RST_SLOT; // RULE2
      slotActive_ff <= vcs_pkg::RST_SLOT; // RULE1
    end else begin
      if (wrSlot) begin
        slotStored_ff <= regWrData[4:0]; // RULE1
      end
      if (inSoftRst) begin
        slotActive_ff <= slotStored_ff; // RULE4
      end
    end
  end

  // Plain read/write registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mcst_ff   <= vcs_pkg::RST_MCST; // RULE6
      level_ff  <= vcs_pkg::RST_LEVEL; // RULE14
      vector_ff <= vcs_pkg::RST_VECTOR; // RULE15
    end else begin
      if (wrMcst) begin
        mcst_ff <= regWrData[7:0]; // RULE5
      end
      if (wrLevel) begin
        level_ff <= regWrData[2:0]; // RULE14
      end
      if (wrVec) begin
        vector_ff <= regWrData[7:0];
      end
    end
  end

  // Purged: set when this board has sent all its chained data
  wire nxtPurged = cbltActive & (purged_ff | cbltDataSent);

  // Status register, rebuilt every cycle; no write path
  wire localReady = (eventsStored != '0);
  wire localBusy  = convBusy | inSoftRst | bufferFull | memTestMode;
  wire levelOn    = (level_ff != vcs_pkg::RST_LEVEL);
  wire evThresh   = (eventTrigger >= eventsStored) & irqRaised & levelOn;
  // Both termination pins high is not a real switch state; read as mixed
  logic [15:0] nxtStatus;

  always_comb begin
    nxtStatus                     = 16'h0000; // RULE24
    nxtStatus[vcs_pkg::ST_DRDY]   = localReady; // RULE16
    nxtStatus[vcs_pkg::ST_GDRDY]  = chainReady; // RULE17
    nxtStatus[vcs_pkg::ST_BUSY]   = localBusy; // RULE18
    nxtStatus[vcs_pkg::ST_GBUSY]  = chainBusy; // RULE19
    nxtStatus[vcs_pkg::ST_PURGED] = purged_ff; // RULE20
    nxtStatus[vcs_pkg::ST_TON]    = termOn & ~termOff; // RULE21
    nxtStatus[vcs_pkg::ST_TOFF]   = termOff & ~termOn; // RULE21
    nxtStatus[vcs_pkg::ST_EVENT_THRESHOLD_FLAG]  = evThresh; // RULE22
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      purged_ff <= 1'b0;
      status_ff <= 16'h0000; // RULE22
    end else begin
      purged_ff <= nxtPurged; // RULE20
      status_ff <= nxtStatus; // RULE25
    end
  end

  // Read mux; unmapped addresses return zero
  logic [15:0] rdMux;

  always_comb begin
    rdMux = 16'h0000;
    if (isHit(regAddr, vcs_pkg::OFF_SLOT)) begin
      rdMux = {11'h000, slotStored_ff};
    end else if (isHit(regAddr, vcs_pkg::OFF_MCST)) begin
      rdMux = {8'h00, mcst_ff};
    end else if (isHit(regAddr, vcs_pkg::OFF_SET1) || isHit(regAddr, vcs_pkg::OFF_CLR1)) begin
      rdMux = ctrl_ff; // RULE9
    end else if (isHit(regAddr, vcs_pkg::OFF_LEVEL)) begin
      rdMux = {13'h0000, level_ff};
    end else if (isHit(regAddr, vcs_pkg::OFF_VECTOR)) begin
      rdMux = {8'h00, vector_ff};
    end else if (isHit(regAddr, vcs_pkg::OFF_STAT1)) begin
      rdMux = status_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdData_ff <= 16'h0000;
      ack_ff    <= 1'b0;
    end else begin
      rdData_ff <= rdStb ? rdMux : 16'h0000;
      ack_ff    <= regAccess;
    end
  end

  // Base address source and interrupter outputs
  // Enable lags the level by one cycle; the level itself shows at once
  wire selReloc = ctrl_ff[vcs_pkg::CTL_SEL];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      base_ff  <= 8'h00;
      irqEn_ff <= 1'b0;
      iack_ff  <= 8'h00;
    end else begin
      base_ff  <= selReloc ? relocBase : switchBase; // RULE12
      irqEn_ff <= levelOn; // RULE14
      iack_ff  <= iackCycle ? vector_ff : 8'h00; // RULE15
    end
  end

  // Output words carry the slot code in use
  vcs_word_tag u_word_tag (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .slotCode     (slotActive_ff), // RULE3 RULE23
    .wordInValid  (wordInValid),
    .wordIn       (wordIn),
    .wordOutValid (wordOutValid),
    .wordOut      (wordOut)
  );

  assign regRdData   = rdData_ff;
  assign regAck      = ack_ff;
  assign moduleReset = modRst_ff;
  assign activeBase  = base_ff;
  assign useReloc    = ctrl_ff[vcs_pkg::CTL_SEL];
  assign mcstAddr    = mcst_ff;
  assign irqLevel    = level_ff;
  assign irqEnable   = irqEn_ff;
  assign iackData    = iack_ff;
  assign slotCode    = slotActive_ff;
endmodule : vcs_ctrl_status_regs

// >>> dv/vcs_host_model.sv
// Host model issuing single register cycles on the register port
`timescale 1ns/1ps
module vcs_host_model (
  // Clock
  input  wire logic        core_clk,
  // Request
  output logic             regAccess,
  output logic             regWrite,
  output logic      [15:0] regAddr,
  output logic      [15:0] regWrData,
  // Answer
  input  wire logic [15:0] regRdData,
  input  wire logic        regAck
);
  int nAckMiss = 0;
  initial begin
    regAccess = 1'b0;
    regWrite = 1'b0;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
  end
  // Pulse for one edge, answer sampled exactly one edge later
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge core_clk);
    regAccess <= 1'b1;
    regWrite <= wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regAccess <= 1'b0;
    // Released lines show the inverse so a stale value never matches
    regAddr <= ~a;
    regWrData <= ~d;
    @(posedge core_clk);
    q = regRdData;
    if (regAck !== 1'b1) nAckMiss++;
  endtask : access
endmodule : vcs_host_model

// >>> dv/vcs_csr_checker.sv
// Assertions on the ports of the control and status register group
`timescale 1ns/1ps
module vcs_csr_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Register port
  input wire logic        regAccess,
  input wire logic        regWrite,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic        regAck,
  // Reset and addressing
  input wire logic        softResetReq,
  input wire logic        moduleReset,
  input wire logic [7:0]  switchBase,
  input wire logic [7:0]  relocBase,
  input wire logic [7:0]  activeBase,
  input wire logic        useReloc,
  input wire logic [7:0]  mcstAddr,
  // Interrupter
  input wire logic        iackCycle,
  input wire logic [2:0]  irqLevel,
  input wire logic        irqEnable,
  input wire logic [7:0]  iackData,
  // Word tagging
  input wire logic        wordInValid,
  input wire logic [26:0] wordIn,
  input wire logic        wordOutValid,
  input wire logic [31:0] wordOut,
  input wire logic [4:0]  slotCode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire       rdAcc = regAccess && !regWrite;
  wire       wrAcc = regAccess && regWrite;
  wire [7:0] wrLow = regWrData[7:0];
  // Held bit as programmed; soft reset leaves it alone
  logic heldMirror_ff;
  wire  nxt_heldMirror = (wrAcc && regAddr == vcs_pkg::OFF_SET1 && regWrData[7]) ? 1'b1 :
                         (wrAcc && regAddr == vcs_pkg::OFF_CLR1 && regWrData[7]) ? 1'b0 : heldMirror_ff;
  always_ff @(posedge core_clk) begin
    heldMirror_ff <= rst_n ? nxt_heldMirror : 1'b0;
  end
  // Base inputs may pass synchronisers, so demand a quiet spell
  sequence s_quiet;
    $past(rst_n) && $stable(useReloc) && $stable(relocBase) && $stable(switchBase);
  endsequence
  a_ack_one_cycle: assert property (regAccess |=> regAck)
    else $error("no acknowledge one cycle after access");
  a_unmapped_read_zero: assert property (rdAcc && regAddr == 16'h1020 |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  a_status_unused_zero: assert property (rdAcc && regAddr == vcs_pkg::OFF_STAT1 |=>
    regRdData[15:9] == 7'h00 && !regRdData[4]) else $error("unused status bits set");
  a_level_gates_irq: assert property ($past(rst_n) && $stable(irqLevel) |-> irqEnable == (irqLevel != 3'h0))
    else $error("interrupt enable disagrees with level");
  a_iack_idle_zero: assert property (!iackCycle |=> iackData == 8'h00)
    else $error("vector driven outside acknowledge");
  a_base_follows_sel: assert property (s_quiet [*4] |-> activeBase == (useReloc ? relocBase : switchBase))
    else $error("active base does not follow select bit");
  a_slot_write_deferred: assert property ($past(rst_n) && !moduleReset && !softResetReq && !$past(softResetReq)
    && !nxt_heldMirror |=> $stable(slotCode) || moduleReset) else $error("slot code changed without reset");
  a_held_keeps_reset: assert property (heldMirror_ff && $past(heldMirror_ff) && $past(heldMirror_ff, 2)
    |-> moduleReset) else $error("held reset not holding module");
  a_word_tagged: assert property (wordInValid |=> wordOutValid && wordOut == {$past(slotCode), $past(wordIn)})
    else $error("output word not tagged with slot code");
  a_mcst_write: assert property (wrAcc && regAddr == vcs_pkg::OFF_MCST |=> mcstAddr == $past(wrLow))
    else $error("multicast address not stored");
  c_held_set: cover property (wrAcc && regAddr == vcs_pkg::OFF_SET1 && regWrData[7]);
  c_iack: cover property (iackCycle ##1 iackData != 8'h00);
  c_word: cover property (wordInValid ##1 wordOutValid);
endmodule : vcs_csr_checker
bind vcs_ctrl_status_regs vcs_csr_checker u_checker (.*);

// >>> dv/vcs_ctrl_status_regs_test.sv
// Self-checking testbench for the control and status register group
`timescale 1ns/1ps
module vcs_ctrl_status_regs_test;
  logic        core_clk, rst_n = 1'b0, softResetReq = 1'b0, iackCycle = 1'b0, berrEvent = 1'b0;
  logic        cbltActive = 1'b0, cbltDataSent = 1'b0, wordInValid = 1'b0;
  logic [26:0] wordIn = 27'h0;
  logic [7:0]  pins = 8'h00;
  logic [4:0]  eventsStored = 5'h00, eventTrigger = 5'h00, slotCode;
  logic [7:0]  switchBase = 8'hC3, relocBase = 8'h3C, activeBase, mcstAddr, iackData;
  logic        regAccess, regWrite, regAck, moduleReset, useReloc, irqEnable, wordOutValid;
  logic [15:0] regAddr, regWrData, regRdData;
  logic [2:0]  irqLevel;
  logic [31:0] wordOut;
  wire convBusy = pins[0], bufferFull = pins[1], memTestMode = pins[2], chainReadyPin = pins[3];
  wire chainBusyPin = pins[4], termAllOnPin = pins[5], termAllOffPin = pins[6], irqRaised = pins[7];
  int n_mismatch = 0, comparisons = 0;
  logic [15:0] rstAddr [5] = '{vcs_pkg::OFF_SLOT, vcs_pkg::OFF_MCST, vcs_pkg::OFF_SET1, vcs_pkg::OFF_LEVEL,
                               vcs_pkg::OFF_VECTOR};
  logic [15:0] rstVal [5] = '{16'h001F, 16'h00AA, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0]  stPins [4] = '{8'h00, 8'h29, 8'hD2, 8'h64};
  logic [4:0]  stStored [4] = '{5'h00, 5'h02, 5'h02, 5'h00}, stTrig [4] = '{5'h00, 5'h01, 5'h02, 5'h00};
  logic [15:0] stExp [4] = '{16'h0000, 16'h0047, 16'h018D, 16'h0004};
  vcs_ctrl_status_regs DUT (.*);
  vcs_host_model HOST (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    HOST.access(1'b1, a, d, q);
  endtask : wr
  task automatic rdChk(input string what, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] q;
    HOST.access(1'b0, a, 16'h0000, q);
    chk(what, q, exp);
  endtask : rdChk
  task automatic hardRst;
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask : hardRst
  task automatic waitFree;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 64 && moduleReset !== 1'b0; i++) @(posedge core_clk);
    chk("reset released", moduleReset, 1'b0);
  endtask : waitFree
  task automatic softRst;
    @(posedge core_clk);
    softResetReq <= 1'b1;
    @(posedge core_clk);
    softResetReq <= 1'b0;
    waitFree();
  endtask : softRst
  task automatic sendWord(input logic [26:0] w, input logic [31:0] exp);
    @(posedge core_clk);
    wordInValid <= 1'b1;
    wordIn <= w;
    @(posedge core_clk);
    wordInValid <= 1'b0;
    wordIn <= ~w;
    @(posedge core_clk);
    chk("tagged word", wordOut, exp);
  endtask : sendWord
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    $display("Watchdog expired");
    end_sim();
  end
  initial begin
    hardRst();
    for (int i = 0; i < 5; i++) rdChk("reset value", rstAddr[i], rstVal[i]);
    rdChk("unmapped", 16'h1020, 16'h0000);
    $display("test reset_values done");
    wr(vcs_pkg::OFF_SET1, 16'hFF77);
    rdChk("set view", vcs_pkg::OFF_SET1, 16'h0010);
    rdChk("clear view", vcs_pkg::OFF_CLR1, 16'h0010);
    chk("reloc base", activeBase, 8'h3C);
    wr(vcs_pkg::OFF_SET1, 16'h0008);
    rdChk("host flag", vcs_pkg::OFF_SET1, 16'h0018);
    softRst();
    rdChk("soft reset", vcs_pkg::OFF_CLR1, 16'h0010);
    wr(vcs_pkg::OFF_CLR1, 16'hFF10);
    rdChk("cleared", vcs_pkg::OFF_SET1, 16'h0000);
    repeat (4) @(posedge core_clk);
    chk("switch base", activeBase, 8'hC3);
    @(posedge core_clk);
    berrEvent <= 1'b1;
    @(posedge core_clk);
    berrEvent <= 1'b0;
    rdChk("transfer error", vcs_pkg::OFF_CLR1, 16'h0008);
    wr(vcs_pkg::OFF_CLR1, 16'h0008);
    rdChk("flag cleared", vcs_pkg::OFF_SET1, 16'h0000);
    $display("test set_clear done");
    wr(vcs_pkg::OFF_SET1, 16'h0080);
    repeat (4) @(posedge core_clk);
    chk("held", moduleReset, 1'b1);
    rdChk("busy in reset", vcs_pkg::OFF_STAT1, 16'h0004);
    chk("still held", moduleReset, 1'b1);
    wr(vcs_pkg::OFF_CLR1, 16'h0080);
    waitFree();
    $display("test held_reset done");
    wr(vcs_pkg::OFF_SLOT, 16'hFFE5);
    rdChk("slot", vcs_pkg::OFF_SLOT, 16'h0005);
    chk("slot deferred", slotCode, 5'h1F);
    sendWord(27'h5A5A5A5, {5'h1F, 27'h5A5A5A5});
    softRst();
    chk("slot applied", slotCode, 5'h05);
    sendWord(27'h2A5A5A5, {5'h05, 27'h2A5A5A5});
    wr(vcs_pkg::OFF_MCST, 16'hFF3C);
    rdChk("mcst", vcs_pkg::OFF_MCST, 16'h003C);
    wr(vcs_pkg::OFF_SET1, 16'h0018);
    hardRst();
    rdChk("mcst hard", vcs_pkg::OFF_MCST, 16'h00AA);
    rdChk("ctrl hard", vcs_pkg::OFF_SET1, 16'h0000);
    chk("slot hard", slotCode, 5'h1F);
    $display("test slot_mcst done");
    wr(vcs_pkg::OFF_LEVEL, 16'hFFFA);
    rdChk("level", vcs_pkg::OFF_LEVEL, 16'h0002);
    chk("irq on", irqEnable, 1'b1);
    wr(vcs_pkg::OFF_VECTOR, 16'hFF5A);
    rdChk("vector", vcs_pkg::OFF_VECTOR, 16'h005A);
    @(posedge core_clk);
    iackCycle <= 1'b1;
    @(posedge core_clk);
    iackCycle <= 1'b0;
    @(posedge core_clk);
    chk("iack data", iackData, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      pins <= stPins[i];
      eventsStored <= stStored[i];
      eventTrigger <= stTrig[i];
      repeat (5) @(posedge core_clk);
      rdChk("status", vcs_pkg::OFF_STAT1, stExp[i]);
    end
    wr(vcs_pkg::OFF_STAT1, 16'hFFFF);
    rdChk("status write", vcs_pkg::OFF_STAT1, 16'h0004);
    pins <= 8'h00;
    cbltActive <= 1'b1;
    repeat (5) @(posedge core_clk);
    rdChk("not purged", vcs_pkg::OFF_STAT1, 16'h0000);
    cbltDataSent <= 1'b1;
    @(posedge core_clk);
    cbltDataSent <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdChk("purged", vcs_pkg::OFF_STAT1, 16'h0020);
    cbltActive <= 1'b0;
    wr(vcs_pkg::OFF_LEVEL, 16'h0000);
    @(posedge core_clk);
    chk("irq off", irqEnable, 1'b0);
    $display("test irq_status done");
    chk("missing acks", HOST.nAckMiss, 32'h0);
    end_sim();
  end
endmodule : vcs_ctrl_status_regs_test
